/* hw/timer_two_map.vh */
/*
 timer two control register map, field positions, reset values and
 register offsets for the APB slave of the timer/counter block.
 assumes inclusion by bare name from the design file.
*/
`ifndef TIMER_TWO_MAP_VH
`define TIMER_TWO_MAP_VH

// --------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------
`define OFS_CONTROL      8'hC8
`define OFS_RELOAD       8'hCC
`define OFS_COUNT        8'hD0
`define OFS_SERIAL       8'hD4

// --------------------------------------------------------------
// control register fields
// --------------------------------------------------------------
`define BIT_OVF          7
`define BIT_EXT_FLAG     6
`define BIT_RX_SEL       5
`define BIT_TX_SEL       4
`define BIT_TRIG_EN      3
`define BIT_RUN          2
`define BIT_CNT_SEL      1
`define BIT_CAP_SEL      0

// serial register fields
`define BIT_UPDOWN       0
`define BIT_IRQ_EN       1
`define BIT_CLKOUT_EN    2

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define RST_CONTROL      8'h00
`define RST_RELOAD       16'h0000
`define RST_COUNT        16'h0000
`define RST_SERIAL       3'h0

`endif

/* hw/timer_two.v */
/*
 sixteen bit timer/counter two with auto-reload, capture, serial baud
 clock supply and clock-out, reached over an APB slave.
 assumes all inputs synchronous to i_clk and a single clock domain.
*/
//Operation
//- overflow flag set unless rx/tx select set
//- trigger falling edge captures/reloads, sets event flag unless rx/tx select set
//- event flag interrupts only when updown disabled
//- rx select picks timer one or two
//- tx select picks timer one or two
//- rx and tx selected independently
//- run bit starts and stops counting
//- counter select picks oscillator or pin edges
//- baud and clock-out share reload registers
//- control resets to zero, bit writable
`timescale 1ns/100ps
`default_nettype none
`include "timer_two_map.vh"

module timer_two (
   input  wire        i_clk,
   input  wire        i_nrst,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output reg         o_pready,
   output reg         o_pslverr,
   input  wire        i_count_input_pin,
   input  wire        i_trigger_pin,
   input  wire        i_timer_one_overflow,
   output reg         o_rx_baud_tick,
   output reg         o_tx_baud_tick,
   output reg         o_clock_out,
   output reg         o_timer_irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg  [7:0]  timer_two_control;
   reg  [15:0] reload_value;
   reg  [15:0] count;
   reg  [2:0]  serial_cfg;
   reg         count_pin_d;
   reg         trig_pin_d;

   wire        overflow_flag           = timer_two_control[`BIT_OVF];
   wire        external_event_flag     = timer_two_control[`BIT_EXT_FLAG];
   wire        rx_clock_select         = timer_two_control[`BIT_RX_SEL];
   wire        tx_clock_select         = timer_two_control[`BIT_TX_SEL];
   wire        external_trigger_enable = timer_two_control[`BIT_TRIG_EN];
   wire        run_control             = timer_two_control[`BIT_RUN];
   wire        counter_select          = timer_two_control[`BIT_CNT_SEL];
   wire        capture_reload_select   = timer_two_control[`BIT_CAP_SEL];
   wire        updown_enable           = serial_cfg[`BIT_UPDOWN];
   wire        irq_enable              = serial_cfg[`BIT_IRQ_EN];
   wire        clkout_enable           = serial_cfg[`BIT_CLKOUT_EN];

   // ------------------------------------------------------------
   // pin edge detection
   // ------------------------------------------------------------
   wire [1:0]  pin_now  = {i_trigger_pin, i_count_input_pin};
   wire [1:0]  pin_last = {trig_pin_d, count_pin_d};
   wire [1:0]  pin_fall;

   genvar      g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_fall
         assign pin_fall[g] = pin_last[g] & ~pin_now[g];
      end
   endgenerate

   // detectors rest high like the pins, so reset gives no false edge
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         count_pin_d <= 1'b1;
         trig_pin_d  <= 1'b1;
      end else begin
         count_pin_d <= i_count_input_pin;
         trig_pin_d  <= i_trigger_pin;
      end
   end

   // ------------------------------------------------------------
   // counting and events
   // ------------------------------------------------------------
   wire        serial_mode  = rx_clock_select | tx_clock_select;
   wire        count_fall   = pin_fall[0];
   wire        trig_fall    = pin_fall[1];
   wire        tick         = run_control &
                              (counter_select ? count_fall : 1'b1);
   wire        overflow     = tick & (count == 16'hFFFF);
   wire        trig_event   = trig_fall & external_trigger_enable &
                              ~serial_mode;
   wire        capture_mode = capture_reload_select & ~serial_mode;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   // a write lands at the edge where the master sees pready high
   wire        access  = i_psel & i_penable & ~o_pready;
   wire        done    = i_psel & i_penable & o_pready;
   wire        wr      = done & i_pwrite;
   wire        hit_ctl = (i_paddr == `OFS_CONTROL);
   wire        hit_rel = (i_paddr == `OFS_RELOAD);
   wire        hit_cnt = (i_paddr == `OFS_COUNT);
   wire        hit_ser = (i_paddr == `OFS_SERIAL);
   wire        mapped  = hit_ctl | hit_rel | hit_cnt | hit_ser;

   // read word of one register, zero for an unmapped address
   function [31:0] read_word;
      input [7:0]  addr;
      input [7:0]  ctl;
      input [15:0] rel;
      input [15:0] cnt;
      input [2:0]  ser;
      begin
         case (addr)
            `OFS_CONTROL: read_word = {24'h000000, ctl};
            `OFS_RELOAD:  read_word = {16'h0000, rel};
            `OFS_COUNT:   read_word = {16'h0000, cnt};
            `OFS_SERIAL:  read_word = {29'h0000000, ser};
            default:      read_word = 32'h00000000;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // next register values
   // ------------------------------------------------------------
   reg  [7:0]  next_control;
   reg  [15:0] next_reload;
   reg  [15:0] next_count;
   reg  [2:0]  next_serial;

   // hardware set of a flag wins over a software clear
   always @* begin
      next_control = timer_two_control;
      if (wr && hit_ctl) begin
         next_control = i_pwdata[7:0];
      end
      if (overflow && !serial_mode) begin
         next_control[`BIT_OVF] = 1'b1;
      end
      if (trig_event) begin
         next_control[`BIT_EXT_FLAG] = 1'b1;
      end
   end

   // reload/capture register shared by baud and clock-out
   always @* begin
      next_reload = reload_value;
      if (trig_event && capture_mode) begin
         next_reload = count;
      end else if (wr && hit_rel) begin
         next_reload = i_pwdata[15:0];
      end
   end

   always @* begin
      next_count = count;
      if (wr && hit_cnt) begin
         next_count = i_pwdata[15:0];
      end else if (overflow || (trig_event && !capture_mode)) begin
         next_count = reload_value;
      end else if (tick) begin
         next_count = count + 16'h0001;
      end
   end

   always @* begin
      next_serial = serial_cfg;
      if (wr && hit_ser) begin
         next_serial = i_pwdata[2:0];
      end
   end

   // ------------------------------------------------------------
   // next output values
   // ------------------------------------------------------------
   reg         next_rx_tick;
   reg         next_tx_tick;
   reg         next_clock_out;
   reg         next_irq;
   reg         next_pready;
   reg         next_pslverr;
   reg  [31:0] next_prdata;

   // serial clocks, each chosen on its own
   always @* begin
      next_rx_tick   = rx_clock_select ? overflow : i_timer_one_overflow;
      next_tx_tick   = tx_clock_select ? overflow : i_timer_one_overflow;
      next_clock_out = o_clock_out;
      if (overflow && clkout_enable) begin
         next_clock_out = ~o_clock_out;
      end
      next_irq       = irq_enable & (next_control[`BIT_OVF] |
                       (next_control[`BIT_EXT_FLAG] & ~updown_enable));
   end

   // apb answer: one wait state, data stands with pready only
   always @* begin
      next_pready  = access;
      next_pslverr = access & ~mapped;
      next_prdata  = 32'h00000000;
      if (access && !i_pwrite) begin
         next_prdata = read_word(i_paddr, timer_two_control, reload_value, count, serial_cfg);
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_two_control <= `RST_CONTROL;
      end else begin
         timer_two_control <= next_control;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         reload_value <= `RST_RELOAD;
      end else begin
         reload_value <= next_reload;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         count <= `RST_COUNT;
      end else begin
         count <= next_count;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         serial_cfg <= `RST_SERIAL;
      end else begin
         serial_cfg <= next_serial;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rx_baud_tick <= 1'b0;
      end else begin
         o_rx_baud_tick <= next_rx_tick;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tx_baud_tick <= 1'b0;
      end else begin
         o_tx_baud_tick <= next_tx_tick;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_clock_out <= 1'b0;
      end else begin
         o_clock_out <= next_clock_out;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_timer_irq <= 1'b0;
      end else begin
         o_timer_irq <= next_irq;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= next_pready;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= next_pslverr;
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_prdata <= 32'h00000000;
      end else begin
         o_prdata <= next_prdata;
      end
   end

endmodule // timer_two
`default_nettype wire

/* testbench/timer_two_checker.sv */
/* checker: apb slave and baud tick assertions for timer_two.
   assumes a bind to timer_two and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module timer_two_checker (
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_timer_one_overflow,
   input wire logic        o_rx_baud_tick,
   input wire logic        o_tx_baud_tick,
   input wire logic        o_clock_out
);
   logic [7:0] c;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // shadow of the control register
   always @(posedge i_clk or negedge i_nrst)
      if (!i_nrst) c <= 8'h00;
      else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'hC8) c <= i_pwdata[7:0];
   AST_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late");
   AST_PULSE: assert property (o_pready |=> !o_pready) else $error("pready held");
   AST_CAUSE: assert property (o_pready |-> i_psel && $past(i_penable)) else $error("stray");
   AST_ERR: assert property (o_pready |-> o_pslverr == !(i_paddr inside {8'hC8, 8'hCC, 8'hD0,
      8'hD4})) else $error("bad pslverr");
   AST_IDLE: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr) else $error("idle");
   AST_RX_T1: assert property (!c[5] && !$past(c[5]) |-> o_rx_baud_tick == $past(
      i_timer_one_overflow)) else $error("rx tick");
   AST_TX_T1: assert property (!c[4] && !$past(c[4]) |-> o_tx_baud_tick == $past(
      i_timer_one_overflow)) else $error("tx tick");
   AST_RX_HALT: assert property (c[5] && $past(c[5]) && !c[2] && !$past(c[2]) && !$past(c[2], 2)
      |-> !o_rx_baud_tick) else $error("tick while stopped");
   cover property (o_pslverr);
   cover property (o_rx_baud_tick && c[5]);
   cover property (o_tx_baud_tick);
   cover property (o_clock_out);
endmodule // timer_two_checker
bind timer_two timer_two_checker i_timer_two_checker (.*);
`default_nettype wire

/* testbench/timer_two_partner.sv */
/* serial port side: timer one overflow source and baud tick counters.
   assumes the clock and reset of timer_two. */
`timescale 1ns/100ps
`default_nettype none
module timer_two_partner #(parameter int PERIOD = 7) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_en,
   input  wire logic i_rx_tick,
   input  wire logic i_tx_tick,
   output var  logic o_ovf,
   output var  int   o_rx_n,
   output var  int   o_tx_n
);
   int k;
   always @(posedge i_clk or negedge i_nrst)
      if (!i_nrst) begin
         k      <= 0;
         o_ovf  <= 1'b0;
         o_rx_n <= 0;
         o_tx_n <= 0;
      end else begin
         k      <= (k == PERIOD - 1) ? 0 : k + 1;
         o_ovf  <= i_en && k == 0;
         o_rx_n <= o_rx_n + int'(i_rx_tick);
         o_tx_n <= o_tx_n + int'(i_tx_tick);
      end
endmodule // timer_two_partner
`default_nettype wire

/* testbench/test_timer_two.sv */
/* self-checking bench for timer_two over apb.
   assumes timer_two, its checker bind and timer_two_partner. */
`timescale 1ns/100ps
`default_nettype none
module test_timer_two;
   logic        i_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, e, t1_en = 0;
   logic        i_count_input_pin = 1, i_trigger_pin = 1;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, r;
   wire logic [31:0] o_prdata;
   wire logic   o_pready, o_pslverr, o_rx_baud_tick, o_tx_baud_tick, o_clock_out, o_timer_irq;
   wire logic   i_timer_one_overflow;
   int          n_fail = 0, checks = 0, cyc = 0, rx_n, tx_n, n0, m0;
   logic [73:0] rows [8] = '{{1'b0, 8'hC8, 64'h0, 1'b0}, {1'b0, 8'hCC, 64'h0, 1'b0},
      {1'b0, 8'hD0, 64'h0, 1'b0}, {1'b0, 8'hE0, 64'h0, 1'b1}, {1'b1, 8'hCC, 32'hFFF0, 33'h0},
      {1'b0, 8'hCC, 32'h0, 32'hFFF0, 1'b0}, {1'b1, 8'hD0, 32'hFFFF, 33'h0},
      {1'b0, 8'hD0, 32'h0, 32'hFFFF, 1'b0}};
   always #50 i_clk = ~i_clk;
   timer_two i_timer_two (.*);
   timer_two_partner i_timer_two_partner (.i_clk, .i_nrst, .i_en(t1_en), .i_rx_tick(o_rx_baud_tick),
      .i_tx_tick(o_tx_baud_tick), .o_ovf(i_timer_one_overflow), .o_rx_n(rx_n), .o_tx_n(tx_n));
   task report_and_stop;
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      r = o_prdata;
      e = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop;
      end
   end
   initial begin
      repeat (20) @(posedge i_clk);
      {i_nrst, t1_en} <= 2'b11;
      foreach (rows[k]) begin
         acc(rows[k][73], rows[k][72:65], rows[k][64:33]);
         if (!rows[k][73]) chk(r, rows[k][32:1]);
         chk({31'h0, e}, {31'h0, rows[k][0]});
      end
      acc(1'b1, 8'hC8, 32'h06);
      rd(8'hC8, 32'h06);
      i_count_input_pin <= 1'b0;
      rd(8'hC8, 32'h86);
      rd(8'hD0, 32'hFFF0);
      t1_en <= 1'b0;
      acc(1'b1, 8'hC8, 32'h24);
      n0 = rx_n;
      m0 = tx_n;
      repeat (40) @(posedge i_clk);
      chk({31'h0, rx_n != n0}, 32'h1);
      chk(32'(tx_n - m0), 32'h0);
      rd(8'hC8, 32'h24);
      acc(1'b1, 8'hC8, 32'h20);
      repeat (3) @(posedge i_clk);
      n0 = rx_n;
      repeat (40) @(posedge i_clk);
      chk(32'(rx_n - n0), 32'h0);
      t1_en <= 1'b1;
      acc(1'b1, 8'hD0, 32'h5A5A);
      acc(1'b1, 8'hC8, 32'h09);
      i_trigger_pin <= 1'b0;
      rd(8'hCC, 32'h5A5A);
      rd(8'hC8, 32'h49);
      acc(1'b1, 8'hD4, 32'h2);
      repeat (2) @(negedge i_clk);
      chk({31'h0, o_timer_irq}, 32'h1);
      acc(1'b1, 8'hD4, 32'h3);
      repeat (2) @(negedge i_clk);
      chk({31'h0, o_timer_irq}, 32'h0);
      @(posedge i_clk);
      i_trigger_pin <= 1'b1;
      acc(1'b1, 8'hC8, 32'h01);
      i_trigger_pin <= 1'b0;
      rd(8'hCC, 32'h5A5A);
      rd(8'hC8, 32'h01);
      // clock-out with counter select kept at zero
      acc(1'b1, 8'hCC, 32'hFFF0);
      acc(1'b1, 8'hD0, 32'hFFF0);
      acc(1'b1, 8'hD4, 32'h4);
      acc(1'b1, 8'hC8, 32'h04);
      n0 = 0;
      e = o_clock_out;
      repeat (72) begin
         @(posedge i_clk);
         if (o_clock_out !== e) n0++;
         e = o_clock_out;
      end
      chk(32'(n0), 32'h4);
      // reset in mid-run
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd(8'hC8, 32'h00);
      rd(8'hD0, 32'h00);
      report_and_stop;
   end
endmodule // test_timer_two
`default_nettype wire
